// ==== rtl/bioe_pkg.sv ====
// Package with operation codes, field widths and reset values for the execute block.
package bioe_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int JUMP_IMM_W = 11;
  localparam int FILE_ADDR_W = 7;
  localparam int LATCH_W = 5;
  localparam int LATCH_LO = 3;
  localparam int LATCH_HI = 4;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] ONE = 8'h01;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BIOE_NOP = 3'h0,
    BIOE_UNCONDITIONAL_JUMP = 3'h1,
    BIOE_INCREMENT_SKIP_IF_ZERO = 3'h2,
    BIOE_INCREMENT_REGISTER = 3'h3,
    BIOE_OR_IMMEDIATE_INTO_ACCUMULATOR = 3'h4,
    BIOE_OR_ACCUMULATOR_WITH_REGISTER = 3'h5
  } bioe_op_t;

endpackage

// ==== rtl/bioe_alu_if.sv ====
// Interface between the execute controller and its result unit.
`timescale 1ns/1ps
interface bioe_alu_if;
  bioe_pkg::bioe_op_t op;
  logic [bioe_pkg::DATA_W-1:0] acc;
  logic [bioe_pkg::DATA_W-1:0] file_data;
  logic [bioe_pkg::DATA_W-1:0] imm;
  logic [bioe_pkg::DATA_W-1:0] result;
  logic result_zero;

  modport ctrl (output op, output acc, output file_data, output imm,
                input result, input result_zero);
  modport alu (input op, input acc, input file_data, input imm,
               output result, output result_zero);
endinterface

// ==== rtl/bioe_alu.sv ====
// Result unit: increment and inclusive OR with zero detection.
`timescale 1ns/1ps
module bioe_alu (
  bioe_alu_if.alu a
);

  always_comb
  begin
    unique case (a.op)
      bioe_pkg::BIOE_INCREMENT_SKIP_IF_ZERO,
      bioe_pkg::BIOE_INCREMENT_REGISTER:
        a.result = a.file_data + bioe_pkg::ONE;
      bioe_pkg::BIOE_OR_IMMEDIATE_INTO_ACCUMULATOR:
        a.result = a.acc | a.imm;
      bioe_pkg::BIOE_OR_ACCUMULATOR_WITH_REGISTER:
        a.result = a.acc | a.file_data;
      default:
        a.result = bioe_pkg::ACC_RESET;
    endcase
  end

  // Zero is judged on the eight-bit result, whatever its destination.
  assign a.result_zero = (a.result == bioe_pkg::ACC_RESET);

endmodule // bioe_alu

// ==== rtl/bioe_core.sv ====
// Execute controller for jump, increment, increment-skip and inclusive OR.
`timescale 1ns/1ps
module bioe_core (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Decoded instruction
  input wire logic i_valid,
  input wire bioe_pkg::bioe_op_t i_op,
  input wire logic [bioe_pkg::JUMP_IMM_W-1:0] i_imm,
  input wire logic [bioe_pkg::FILE_ADDR_W-1:0] i_file_addr,
  input wire logic i_dest,
  // Register file read data and latch
  input wire logic [bioe_pkg::DATA_W-1:0] i_file_data,
  input wire logic [bioe_pkg::LATCH_W-1:0] i_program_counter_high_latch,
  // Handshake to fetch
  output logic o_ready,
  output logic o_discard,
  // Program counter
  output logic o_program_counter_load,
  output logic [bioe_pkg::PC_W-1:0] o_program_counter,
  // Register file write
  output logic o_file_we,
  output logic [bioe_pkg::FILE_ADDR_W-1:0] o_file_addr,
  output logic [bioe_pkg::DATA_W-1:0] o_file_wdata,
  // Accumulator and status
  output logic [bioe_pkg::DATA_W-1:0] o_accumulator,
  output logic o_zero
);

  // ----------------------------------------------------------------
  // State and result unit
  // ----------------------------------------------------------------
  typedef enum logic {BIOE_S_ISSUE, BIOE_S_SECOND} bioe_state_t;

  bioe_state_t state;
  bioe_alu_if alu_bus ();
  logic take;
  logic is_jump;
  logic is_skip;
  logic is_inc;
  logic is_orw;
  logic is_orl;
  logic skip_hit;
  logic updates_zero;
  logic routes_result;
  logic [bioe_pkg::PC_W-1:0] next_program_counter;

  bioe_alu u_alu (
    .a (alu_bus.alu)
  );

  assign alu_bus.op = i_op;
  assign alu_bus.acc = o_accumulator;
  assign alu_bus.file_data = i_file_data;
  assign alu_bus.imm = i_imm[bioe_pkg::DATA_W-1:0];

  assign take = i_ce && i_valid && (state == BIOE_S_ISSUE);
  assign skip_hit = is_skip && alu_bus.result_zero;
  // Only latch bits 4:3 reach the counter; the rest of the latch is ignored.
  assign next_program_counter = {
    i_program_counter_high_latch[bioe_pkg::LATCH_HI:bioe_pkg::LATCH_LO],
    i_imm};

  // ----------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------
  // Decoding once here keeps the routing and flag processes in step, and an
  // unused code then has no side effect anywhere.
  always_comb
  begin
    is_jump = 1'b0;
    is_skip = 1'b0;
    is_inc = 1'b0;
    is_orw = 1'b0;
    is_orl = 1'b0;
    updates_zero = 1'b0;
    routes_result = 1'b0;
    unique case (i_op)
      bioe_pkg::BIOE_NOP:
      begin
        // A no-operation retires with no effect.
      end
      bioe_pkg::BIOE_UNCONDITIONAL_JUMP:
      begin
        is_jump = 1'b1;
      end
      bioe_pkg::BIOE_INCREMENT_SKIP_IF_ZERO:
      begin
        is_skip = 1'b1;
        routes_result = 1'b1;
      end
      bioe_pkg::BIOE_INCREMENT_REGISTER:
      begin
        is_inc = 1'b1;
        routes_result = 1'b1;
        updates_zero = 1'b1;
      end
      bioe_pkg::BIOE_OR_IMMEDIATE_INTO_ACCUMULATOR:
      begin
        is_orl = 1'b1;
        updates_zero = 1'b1;
      end
      bioe_pkg::BIOE_OR_ACCUMULATOR_WITH_REGISTER:
      begin
        is_orw = 1'b1;
        routes_result = 1'b1;
        updates_zero = 1'b1;
      end
      default:
      begin
        // Codes six and seven are not instructions; they retire with no effect,
        // since the block has no way to report them.
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Two-cycle sequencing
  // ----------------------------------------------------------------
  // A jump or a taken skip holds off fetch for one extra cycle, the slot in
  // which the discarded instruction would otherwise have executed.
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      state <= BIOE_S_ISSUE;
      o_ready <= 1'b0;
    end
    else if (i_ce)
    begin
      unique case (state)
        BIOE_S_ISSUE:
        begin
          if (take && (is_jump || skip_hit))
          begin
            state <= BIOE_S_SECOND;
            o_ready <= 1'b0;
          end
          else
          begin
            o_ready <= 1'b1;
          end
        end
        BIOE_S_SECOND:
        begin
          state <= BIOE_S_ISSUE;
          o_ready <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fetch side pulses
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      o_discard <= 1'b0;
      o_program_counter_load <= 1'b0;
      o_program_counter <= bioe_pkg::PC_RESET;
    end
    else if (i_ce)
    begin
      o_discard <= take && skip_hit;
      o_program_counter_load <= take && is_jump;
      if (take && is_jump)
      begin
        o_program_counter <= next_program_counter;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result routing
  // ----------------------------------------------------------------
  // A result lands in exactly one place, the accumulator or the addressed
  // register, so no instruction ever changes both.
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      o_file_we <= 1'b0;
      o_file_addr <= '0;
      o_file_wdata <= bioe_pkg::ACC_RESET;
      o_accumulator <= bioe_pkg::ACC_RESET;
    end
    else if (i_ce)
    begin
      o_file_we <= 1'b0;
      if (take && routes_result)
      begin
        if (i_dest == bioe_pkg::DEST_FILE)
        begin
          o_file_we <= 1'b1;
          o_file_addr <= i_file_addr;
          o_file_wdata <= alu_bus.result;
        end
        else
        begin
          o_accumulator <= alu_bus.result;
        end
      end
      else if (take && is_orl)
      begin
        o_accumulator <= alu_bus.result;
      end
    end
  end

  // ----------------------------------------------------------------
  // Zero flag
  // ----------------------------------------------------------------
  // Jump and increment-skip leave the flag alone.
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      o_zero <= 1'b0;
    end
    else if (i_ce && take && updates_zero)
    begin
      o_zero <= alu_bus.result_zero;
    end
  end

endmodule // bioe_core

// ==== verification/bioe_file_model.sv ====
// Register file model on the far side of the execute block.
`timescale 1ns/1ps
module bioe_file_model (
  // Clock and access
  input wire logic i_mclk,
  input wire logic [6:0] i_addr,
  input wire logic i_we,
  input wire logic [6:0] i_waddr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_data
);
  logic [7:0] mem [128];
  // The lower half starts at ff, so increments wrap to zero early in the run.
  initial for (int i = 0; i < 128; i++) mem[i] = (i < 64) ? 8'hff : 8'h00;
  // A write still pending is forwarded, as fetch must present fresh read data.
  assign o_data = (i_we && i_waddr == i_addr) ? i_wdata : mem[i_addr];
  always @(posedge i_mclk) if (i_we) mem[i_waddr] <= i_wdata;
endmodule // bioe_file_model

// ==== verification/bioe_core_asserts.sv ====
// Port assertions for the execute block.
`timescale 1ns/1ps
module bioe_core_asserts (
  // Clock, reset and instruction
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_valid,
  input wire bioe_pkg::bioe_op_t i_op,
  input wire logic [10:0] i_imm,
  input wire logic i_dest,
  input wire logic [7:0] i_file_data,
  input wire logic [4:0] i_program_counter_high_latch,
  // Results
  input wire logic o_ready,
  input wire logic o_discard,
  input wire logic o_program_counter_load,
  input wire logic [12:0] o_program_counter,
  input wire logic o_file_we,
  input wire logic [7:0] o_file_wdata,
  input wire logic [7:0] o_accumulator,
  input wire logic o_zero
);
  logic [2:0] op;
  assign op = (i_ce && i_valid && o_ready) ? i_op : 3'h0;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  a_jump_low_bits:
    assert property (op == 3'h1 |=> o_program_counter_load && o_program_counter[10:0] ==
      $past(i_imm)) else $error("jump low bits wrong");
  a_jump_high_bits:
    assert property (op == 3'h1 |=> o_program_counter[12:11] ==
      $past(i_program_counter_high_latch[4:3])) else $error("jump high bits wrong");
  a_jump_stall:
    assert property (op == 3'h1 |=> !o_ready) else $error("jump did not hold off fetch");
  a_jump_resume:
    assert property (op == 3'h1 ##1 i_ce |=> o_ready) else $error("jump not two cycles");
  a_flag_kept:
    assert property (op inside {3'h1, 3'h2} |=> $stable(o_zero)) else $error("flag changed");
  a_skip_taken:
    assert property (op == 3'h2 && i_file_data == 8'hff |=> o_discard && !o_ready)
      else $error("skip not taken");
  a_skip_resume:
    assert property (op == 3'h2 && i_file_data == 8'hff ##1 i_ce |=> o_ready && !o_discard)
      else $error("skip not two cycles");
  a_skip_passed:
    assert property (op == 3'h2 && i_file_data != 8'hff |=> !o_discard && o_ready)
      else $error("skip taken wrongly");
  a_inc_write:
    assert property (op inside {3'h2, 3'h3} && i_dest |=> o_file_we &&
      o_file_wdata == $past(i_file_data) + 8'h01) else $error("increment write wrong");
  a_zero_flag:
    assert property (op inside {3'h3, 3'h4, 3'h5} |=> o_zero ==
      ((o_file_we ? o_file_wdata : o_accumulator) == 8'h00)) else $error("zero flag wrong");
  c_jump: cover property (op == 3'h1);
  c_discard: cover property (o_discard);
  c_write: cover property (o_file_we);
  c_freeze: cover property (!i_ce && !o_ready);
endmodule // bioe_core_asserts
bind bioe_core bioe_core_asserts chk (.i_mclk, .i_rstn, .i_ce, .i_valid, .i_op, .i_imm, .i_dest,
  .i_file_data, .i_program_counter_high_latch, .o_ready, .o_discard, .o_program_counter_load,
  .o_program_counter, .o_file_we, .o_file_wdata, .o_accumulator, .o_zero);

// ==== verification/bioe_bench.sv ====
// Self-checking random bench for the execute block.
`timescale 1ns/1ps
module bioe_bench;
  logic i_mclk = 0, i_rstn = 0, i_ce = 1, i_valid = 0, i_dest = 0;
  bioe_pkg::bioe_op_t i_op = bioe_pkg::BIOE_NOP;
  logic [10:0] i_imm = '0;
  logic [6:0] i_file_addr = '0, o_file_addr, e_fa = '0;
  logic [4:0] i_program_counter_high_latch = '0;
  logic [7:0] i_file_data, o_file_wdata, o_accumulator, e_acc = 0, e_wd = 0, res;
  logic [12:0] o_program_counter, e_pc = 0;
  logic o_ready, o_discard, o_program_counter_load, o_file_we, o_zero;
  logic e_z = 0, e_we = 0, e_ld = 0, e_dc = 0, tk;
  int seed = 39, miscompares = 0, n_checks = 0;
  always #20 i_mclk = ~i_mclk;
  bioe_core dut (.i_mclk, .i_rstn, .i_ce, .i_valid, .i_op, .i_imm, .i_file_addr, .i_dest,
    .i_file_data, .i_program_counter_high_latch, .o_ready, .o_discard, .o_program_counter_load,
    .o_program_counter, .o_file_we, .o_file_addr, .o_file_wdata, .o_accumulator, .o_zero);
  bioe_file_model regs (.i_mclk, .i_addr(i_file_addr), .i_we(o_file_we), .i_waddr(o_file_addr),
    .i_wdata(o_file_wdata), .o_data(i_file_data));
  function automatic logic [7:0] expect_result(logic [2:0] op, logic [7:0] acc, f, k);
    return op == 3'h4 ? acc | k : op == 3'h5 ? acc | f : f + 8'h01;
  endfunction
  task automatic check(string what, logic [12:0] seen, logic [12:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // The run needs about 615 cycles; the limit leaves a wide margin.
  initial
  begin
    #40000;
    miscompares++;
    conclude();
  end
  initial
  begin
    repeat (12) @(negedge i_mclk);
    i_rstn = 1;
    @(negedge i_mclk);
    for (int n = 0; n < 600; n++)
    begin
      @(negedge i_mclk);
      check("ready", o_ready, !(e_ld || e_dc));
      check("acc", o_accumulator, e_acc);
      check("zero", o_zero, e_z);
      check("we", o_file_we, e_we);
      if (e_we) check("wdata", o_file_wdata, e_wd);
      if (e_we) check("waddr", o_file_addr, e_fa);
      check("pc", o_program_counter, e_pc);
      check("load", o_program_counter_load, e_ld);
      check("discard", o_discard, e_dc);
      // The first six offers walk codes five down to zero on the wrapping address, refusals included.
      i_ce = n < 6 || $random(seed) % 8 != 0;
      i_valid = n < 6 || $random(seed) % 4 != 0;
      i_op = bioe_pkg::bioe_op_t'(3'(n < 6 ? 5 - n : {$random(seed)} % 6));
      i_imm = 11'($random(seed));
      i_file_addr = n < 6 ? 7'h00 : 7'($random(seed));
      i_dest = n < 3 || 1'($random(seed));
      i_program_counter_high_latch = 5'($random(seed));
      #1;
      // A low enable freezes the block, pulses included, so expectations stand.
      tk = i_ce && i_valid && !(e_ld || e_dc);
      if (i_ce)
        {e_we, e_ld, e_dc} = 3'h0;
      if (tk && i_op == bioe_pkg::BIOE_UNCONDITIONAL_JUMP)
        {e_ld, e_pc} = {1'b1, i_program_counter_high_latch[4:3], i_imm};
      else if (tk && i_op != bioe_pkg::BIOE_NOP)
      begin
        res = expect_result(i_op, e_acc, i_file_data, i_imm[7:0]);
        if (i_op == bioe_pkg::BIOE_INCREMENT_SKIP_IF_ZERO)
          e_dc = res == 8'h00;
        else
          e_z = res == 8'h00;
        if (i_dest && i_op != bioe_pkg::BIOE_OR_IMMEDIATE_INTO_ACCUMULATOR)
          {e_we, e_fa, e_wd} = {1'b1, i_file_addr, res};
        else
          e_acc = res;
      end
    end
    conclude();
  end
endmodule // bioe_bench
